// ### cycle_timer.sv
`timescale 1ns/100ps
// loadable down-counter that reports expiry
module cycle_timer #(
  parameter int width = 20
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // load and status
  input wire logic load,
  input wire logic [width-1:0] load_value,
  output logic busy,
  output logic done
);
  logic [width-1:0] count;
  logic [width-1:0] next_count;
  logic next_done;
  // counting down; done pulses on the cycle the count reaches zero
  always_comb begin
    next_count = count;
    next_done = 1'b0;
    if (load) begin
      next_count = load_value;
    end else if (count != '0) begin
      next_count = count - 1'b1;
      next_done = (count == {{(width-1){1'b0}}, 1'b1});
    end
  end
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= '0;
      done <= 1'b0;
    end else begin
      count <= next_count;
      done <= next_done;
    end
  end
  assign busy = (count != '0);
endmodule

// ### flash_cmd_pkg.sv
// constants for the serial flash erase / power / id command block
package flash_cmd_pkg;
  localparam logic [7:0] op_block_erase_32k = 8'h52;
  localparam logic [7:0] op_block_erase_64k = 8'hd8;
  localparam logic [7:0] op_full_erase_a = 8'h60;
  localparam logic [7:0] op_full_erase_b = 8'hc7;
  localparam logic [7:0] op_write_enable = 8'h06;
  localparam logic [7:0] op_deep_sleep = 8'hb9;
  localparam logic [7:0] op_wake_and_id = 8'hab;
  localparam logic [7:0] op_maker_part_id = 8'h90;
  localparam logic [7:0] op_reset_enable = 8'h66;
  localparam logic [7:0] op_reset = 8'h99;
  localparam int addr_w = 24;
  localparam int blk32_shift = 15;
  localparam int blk64_shift = 16;
  // bit counts on the link
  localparam logic [7:0] bits_opcode = 8'h08;
  localparam logic [7:0] bits_addr_done = 8'h20;
  // timings in microseconds, clock period in ns
  localparam int clk_period_ns = 40;
  localparam int block_erase_time_us = 1000;
  localparam int full_erase_time_us = 10000;
  localparam int sleep_entry_delay_us = 3;
  localparam int wake_delay_us = 3;
  localparam int wake_id_delay_us = 3;
  localparam int block_erase_cycles = block_erase_time_us * 1000 / clk_period_ns;
  localparam int full_erase_cycles = full_erase_time_us * 1000 / clk_period_ns;
  localparam int sleep_entry_cycles = (sleep_entry_delay_us * 1000 + clk_period_ns - 1)
                                      / clk_period_ns;
  localparam int wake_cycles = (wake_delay_us * 1000 + clk_period_ns - 1) / clk_period_ns;
  localparam int wake_id_cycles = (wake_id_delay_us * 1000 + clk_period_ns - 1)
                                  / clk_period_ns;
  localparam logic [7:0] maker_id_default = 8'h5a;
  localparam logic [7:0] part_id_default = 8'h17;
endpackage

// ### flash_erase_power_id.sv
`timescale 1ns/100ps
// serial flash command handling: block/full erase, deep sleep, wake and id reads
// Summary of operation
// - 52h plus address erases containing 32KB block
// - d8h plus address erases containing 64KB block
// - 60h or c7h alone erase whole array
// - erase runs only with write latch set
// - block erase needs select rise after address
// - full erase/sleep need rise after opcode
// - select rise starts timed erase of right length
// - in-progress flag high throughout erase, readable
// - write latch cleared before erase finishes
// - protected block erase is refused
// - full erase only with no protection
// - b9h enters sleep after entry delay
// - in sleep only wake or reset pair
// - select high while idle means standby
// - sleep request refused during busy cycle
// - power-up starts in standby
// - bare abh wakes after wake delay
// - abh plus three dummies repeats part id
// - wake with id uses its own delay setting, equal to the plain wake delay by default
// - wake/id ignored while operation in progress
// - 90h streams maker/part id by address
module flash_erase_power_id #(
  parameter int erase_cycles_block = flash_cmd_pkg::block_erase_cycles,
  parameter int erase_cycles_full = flash_cmd_pkg::full_erase_cycles,
  parameter int sleep_cycles = flash_cmd_pkg::sleep_entry_cycles,
  parameter int wake_plain_cycles = flash_cmd_pkg::wake_cycles,
  parameter int wake_with_id_cycles = flash_cmd_pkg::wake_id_cycles,
  parameter logic [7:0] maker_id = flash_cmd_pkg::maker_id_default, // arbitrary value
  parameter logic [7:0] part_id = flash_cmd_pkg::part_id_default // arbitrary value
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // serial link pins
  input wire logic chip_sel_n,
  input wire logic serial_clk,
  input wire logic serial_in,
  output logic serial_out,
  output logic serial_out_en,
  // protection configuration
  input wire logic [4:0] protect_range,
  input wire logic protect_complement,
  // status
  output logic write_latch_flag,
  output logic op_in_progress_flag,
  output logic deep_sleep,
  output logic standby,
  // erase request to the array
  output logic erase_pulse,
  output logic [1:0] erase_kind,
  output logic [23:0] erase_base
);
  localparam int tw = 20;
  typedef enum logic [3:0] {
    st_idle = 4'b0001,
    st_erase = 4'b0010,
    st_sleep_enter = 4'b0100,
    st_sleep = 4'b1000
  } mode_e;

  logic cs_lvl, cs_rise, cs_fall;
  logic sck_lvl, sck_rise, sck_fall;
  logic si_lvl;
  logic si_s1;
  logic [7:0] opcode;
  logic [23:0] addr;
  logic [7:0] bit_cnt;
  logic [7:0] out_byte;
  logic [2:0] out_idx;
  logic out_sel;
  logic reset_armed;
  logic wake_hold;
  mode_e mode;
  logic [7:0] next_opcode;
  logic [23:0] next_addr;
  logic [7:0] next_bit_cnt;
  logic [2:0] next_out_idx;
  logic next_out_sel;
  logic next_serial_out, next_serial_out_en;
  logic next_reset_armed, next_wake_hold;
  mode_e next_mode;
  logic next_wel, next_wip, next_deep, next_standby;
  logic next_erase_pulse;
  logic [1:0] next_erase_kind;
  logic [23:0] next_erase_base;
  logic tmr_load;
  logic [tw-1:0] tmr_value;
  logic tmr_busy, tmr_done;
  logic blk_protected, full_allowed;

  sync_edge u_cs (.core_clk(core_clk), .rst_n(rst_n), .async_in(chip_sel_n),
    .reset_level(1'b1), .level(cs_lvl), .rise(cs_rise), .fall(cs_fall));
  sync_edge u_sck (.core_clk(core_clk), .rst_n(rst_n), .async_in(serial_clk),
    .reset_level(1'b1), .level(sck_lvl), .rise(sck_rise), .fall(sck_fall));
  cycle_timer #(.width(tw)) u_tmr (.core_clk(core_clk), .rst_n(rst_n), .load(tmr_load),
    .load_value(tmr_value), .busy(tmr_busy), .done(tmr_done));

  // data in is delayed to line up with the clock's two-flop path
  logic si_s0;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      si_s0 <= 1'b0;
      si_s1 <= 1'b0;
    end else begin
      si_s0 <= serial_in;
      si_s1 <= si_s0;
    end
  end
  assign si_lvl = si_s1;

  // protection: low three range bits select nothing when all zero; complement inverts
  always_comb begin
    blk_protected = ((protect_range[2:0] != 3'h0) ^ protect_complement);
    full_allowed = ((protect_range[2:0] == 3'h0) && !protect_complement) ||
                   ((protect_range[2:0] == 3'h7) && protect_complement);
  end

  // command decode, shifting and the mode machine
  always_comb begin
    next_opcode = opcode;
    next_addr = addr;
    next_bit_cnt = bit_cnt;
    next_out_idx = out_idx;
    next_out_sel = out_sel;
    next_serial_out = serial_out;
    next_serial_out_en = serial_out_en;
    next_reset_armed = reset_armed;
    next_wake_hold = wake_hold;
    next_mode = mode;
    next_wel = write_latch_flag;
    next_wip = op_in_progress_flag;
    next_deep = deep_sleep;
    next_standby = standby;
    next_erase_pulse = 1'b0;
    next_erase_kind = erase_kind;
    next_erase_base = erase_base;
    tmr_load = 1'b0;
    tmr_value = '0;
    if (cs_fall) begin
      next_bit_cnt = 8'h00;
      next_opcode = 8'h00;
      next_standby = 1'b0;
      next_out_idx = 3'h7;
    end
    if (!cs_lvl && sck_rise) begin
      if (bit_cnt < flash_cmd_pkg::bits_opcode) begin
        next_opcode = {opcode[6:0], si_lvl};
      end else if (bit_cnt < flash_cmd_pkg::bits_addr_done) begin
        next_addr = {addr[22:0], si_lvl};
      end
      if (bit_cnt != 8'hff) begin
        next_bit_cnt = bit_cnt + 8'h01;
      end
    end
    // id output on falling edges once opcode and three bytes are in
    if (!cs_lvl && sck_fall && bit_cnt >= flash_cmd_pkg::bits_addr_done &&
        mode != st_erase && !op_in_progress_flag) begin
      if (opcode == flash_cmd_pkg::op_wake_and_id && mode != st_sleep_enter) begin
        next_serial_out_en = 1'b1;
        next_serial_out = part_id[out_idx];
        next_out_idx = out_idx - 3'h1;
        if (mode == st_sleep) begin
          next_wake_hold = 1'b1;
        end
      end else if (opcode == flash_cmd_pkg::op_maker_part_id && mode == st_idle) begin
        if (bit_cnt == flash_cmd_pkg::bits_addr_done && out_idx == 3'h7 &&
            serial_out_en == 1'b0) begin
          next_out_sel = addr[0];
        end
        next_serial_out_en = 1'b1;
        next_serial_out = (serial_out_en ? out_sel : addr[0]) ? part_id[out_idx]
                                                               : maker_id[out_idx];
        next_out_idx = out_idx - 3'h1;
        if (out_idx == 3'h0) begin
          next_out_sel = ~(serial_out_en ? out_sel : addr[0]);
        end
      end
    end
    if (cs_rise) begin
      next_serial_out_en = 1'b0;
      next_serial_out = 1'b0;
      next_standby = (mode == st_idle) && !op_in_progress_flag;
      unique case (mode)
        st_idle: begin
          if (bit_cnt == flash_cmd_pkg::bits_opcode &&
              opcode == flash_cmd_pkg::op_write_enable) begin
            next_wel = 1'b1;
          end else if (bit_cnt == flash_cmd_pkg::bits_addr_done && write_latch_flag &&
                       !blk_protected &&
                       (opcode == flash_cmd_pkg::op_block_erase_32k ||
                        opcode == flash_cmd_pkg::op_block_erase_64k)) begin
            next_mode = st_erase;
            next_wip = 1'b1;
            next_standby = 1'b0;
            tmr_load = 1'b1;
            tmr_value = tw'(erase_cycles_block);
            next_erase_pulse = 1'b1;
            if (opcode == flash_cmd_pkg::op_block_erase_32k) begin
              next_erase_kind = 2'h1;
              next_erase_base = {addr[23:flash_cmd_pkg::blk32_shift],
                                 {flash_cmd_pkg::blk32_shift{1'b0}}};
            end else begin
              next_erase_kind = 2'h2;
              next_erase_base = {addr[23:flash_cmd_pkg::blk64_shift],
                                 {flash_cmd_pkg::blk64_shift{1'b0}}};
            end
          end else if (bit_cnt == flash_cmd_pkg::bits_opcode && write_latch_flag &&
                       full_allowed &&
                       (opcode == flash_cmd_pkg::op_full_erase_a ||
                        opcode == flash_cmd_pkg::op_full_erase_b)) begin
            next_mode = st_erase;
            next_wip = 1'b1;
            next_standby = 1'b0;
            tmr_load = 1'b1;
            tmr_value = tw'(erase_cycles_full);
            next_erase_pulse = 1'b1;
            next_erase_kind = 2'h3;
            next_erase_base = 24'h000000;
          end else if (bit_cnt == flash_cmd_pkg::bits_opcode &&
                       opcode == flash_cmd_pkg::op_deep_sleep) begin
            next_mode = st_sleep_enter;
            next_standby = 1'b0;
            tmr_load = 1'b1;
            tmr_value = tw'(sleep_cycles);
          end
        end
        st_erase: begin
          // sleep and wake/id are refused here; the cycle runs on
          next_standby = 1'b0;
        end
        st_sleep_enter: begin
          next_standby = 1'b0;
        end
        st_sleep: begin
          next_standby = 1'b0;
          if (opcode == flash_cmd_pkg::op_wake_and_id &&
              (bit_cnt == flash_cmd_pkg::bits_opcode || wake_hold)) begin
            tmr_load = 1'b1;
            tmr_value = wake_hold ? tw'(wake_with_id_cycles)
                                  : tw'(wake_plain_cycles);
            next_wake_hold = 1'b1;
            next_reset_armed = 1'b0;
          end else if (bit_cnt == flash_cmd_pkg::bits_opcode &&
                       opcode == flash_cmd_pkg::op_reset_enable) begin
            next_reset_armed = 1'b1;
          end else if (bit_cnt == flash_cmd_pkg::bits_opcode && reset_armed &&
                       opcode == flash_cmd_pkg::op_reset) begin
            next_mode = st_idle;
            next_deep = 1'b0;
            next_wel = 1'b0;
            next_reset_armed = 1'b0;
            next_wake_hold = 1'b0;
            next_standby = 1'b1;
          end else begin
            next_reset_armed = 1'b0;
          end
        end
        default: begin
          next_mode = st_idle;
        end
      endcase
    end
    // timer expiry closes erase, sleep entry and wake recovery
    if (tmr_done) begin
      if (mode == st_erase) begin
        next_mode = st_idle;
        next_wip = 1'b0;
        next_standby = cs_lvl;
      end else if (mode == st_sleep_enter) begin
        next_mode = st_sleep;
        next_deep = 1'b1;
      end else if (mode == st_sleep && wake_hold) begin
        next_mode = st_idle;
        next_deep = 1'b0;
        next_wake_hold = 1'b0;
        next_standby = cs_lvl;
      end
    end
    // latch clears on the first busy cycle, well before the cycle ends
    if (mode == st_erase && tmr_busy) begin
      next_wel = 1'b0;
    end
  end

  // state registers except the data-in delay flops; reset lands in standby
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      opcode <= 8'h00;
      addr <= 24'h000000;
      bit_cnt <= 8'h00;
      out_idx <= 3'h7;
      out_sel <= 1'b0;
      serial_out <= 1'b0;
      serial_out_en <= 1'b0;
      reset_armed <= 1'b0;
      wake_hold <= 1'b0;
      mode <= st_idle;
      write_latch_flag <= 1'b0;
      op_in_progress_flag <= 1'b0;
      deep_sleep <= 1'b0;
      standby <= 1'b1;
      erase_pulse <= 1'b0;
      erase_kind <= 2'h0;
      erase_base <= 24'h000000;
    end else begin
      opcode <= next_opcode;
      addr <= next_addr;
      bit_cnt <= next_bit_cnt;
      out_idx <= next_out_idx;
      out_sel <= next_out_sel;
      serial_out <= next_serial_out;
      serial_out_en <= next_serial_out_en;
      reset_armed <= next_reset_armed;
      wake_hold <= next_wake_hold;
      mode <= next_mode;
      write_latch_flag <= next_wel;
      op_in_progress_flag <= next_wip;
      deep_sleep <= next_deep;
      standby <= next_standby;
      erase_pulse <= next_erase_pulse;
      erase_kind <= next_erase_kind;
      erase_base <= next_erase_base;
    end
  end
  logic unused_sck;
  assign unused_sck = sck_lvl;
endmodule

// ### flash_erase_power_id_properties.sv
`timescale 1ns/100ps
// concurrent checks on the erase, sleep and id command block ports
module flash_erase_power_id_chk #(
  parameter int erase_cycles_block = 50,
  parameter int erase_cycles_full = 80
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // link and protection
  input wire logic chip_sel_n,
  input wire logic serial_out_en,
  input wire logic [4:0] protect_range,
  input wire logic protect_complement,
  // status and erase request
  input wire logic write_latch_flag,
  input wire logic op_in_progress_flag,
  input wire logic deep_sleep,
  input wire logic standby,
  input wire logic erase_pulse,
  input wire logic [1:0] erase_kind,
  input wire logic [23:0] erase_base
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  logic [15:0] busy_cnt;
  logic [15:0] next_busy_cnt;
  logic full_run;
  logic next_full_run;
  logic [15:0] run_len;
  // count busy cycles; kind is held from launch so the length is known at the end
  always_comb begin
    next_busy_cnt = op_in_progress_flag ? busy_cnt + 16'h0001 : 16'h0000;
    next_full_run = erase_pulse ? (erase_kind == 2'h3) : full_run;
  end
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_cnt <= 16'h0000;
      full_run <= 1'b0;
    end else begin
      busy_cnt <= next_busy_cnt;
      full_run <= next_full_run;
    end
  end
  assign run_len = full_run ? 16'(erase_cycles_full) : 16'(erase_cycles_block);
  sequence s_busy_up;
    ##[0:1] op_in_progress_flag;
  endsequence
  sequence s_latch_gone;
    ##[1:4] !write_latch_flag;
  endsequence
  chk_launch_busy: assert property (erase_pulse |-> s_busy_up)
    else $error("erase launched without busy flag");
  chk_latch_needed: assert property (erase_pulse |-> $past(write_latch_flag))
    else $error("erase launched without write latch");
  chk_latch_cleared: assert property (erase_pulse |-> s_latch_gone)
    else $error("write latch not cleared after launch");
  chk_erase_length: assert property ($fell(op_in_progress_flag) |->
    busy_cnt >= run_len - 16'h0001 && busy_cnt <= run_len + 16'h0001)
    else $error("erase busy time wrong");
  chk_base_aligned: assert property (erase_pulse && erase_kind != 2'h3 |->
    (erase_kind == 2'h1 ? erase_base[14:0] == 15'h0 : erase_base[15:0] == 16'h0))
    else $error("block base not aligned");
  chk_block_open: assert property (erase_pulse && erase_kind != 2'h3 |->
    (protect_range[2:0] != 3'h0) == protect_complement)
    else $error("protected block erased");
  chk_full_open: assert property (erase_pulse && erase_kind == 2'h3 |->
    erase_base == 24'h0 && (protect_range[2:0] == {3{protect_complement}}))
    else $error("full erase while protected");
  chk_sleep_idle: assert property (deep_sleep |-> !op_in_progress_flag && !erase_pulse)
    else $error("erase activity in deep sleep");
  chk_standby_idle: assert property (standby |-> !op_in_progress_flag && !deep_sleep)
    else $error("standby while busy or asleep");
  chk_id_release: assert property ($rose(chip_sel_n) ##5 chip_sel_n |-> !serial_out_en)
    else $error("id output still driven after deselect");
endmodule

bind flash_erase_power_id flash_erase_power_id_chk #(
  .erase_cycles_block(erase_cycles_block),
  .erase_cycles_full(erase_cycles_full)
) i_chk (.core_clk, .rst_n, .chip_sel_n, .serial_out_en, .protect_range,
  .protect_complement, .write_latch_flag, .op_in_progress_flag, .deep_sleep, .standby,
  .erase_pulse, .erase_kind, .erase_base);

// ### flash_erase_power_id_test.sv
`timescale 1ns/100ps
// self-checking bench for the erase, sleep and id command block
module flash_erase_power_id_test;
  localparam logic [7:0] mk = 8'h3c; // arbitrary value
  localparam logic [7:0] pt = 8'h81; // arbitrary value
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [4:0] protect_range = 5'h00;
  logic protect_complement = 1'b0;
  logic chip_sel_n, serial_clk, serial_in, serial_out, serial_out_en;
  logic so_line;
  logic write_latch_flag, op_in_progress_flag, deep_sleep, standby, erase_pulse;
  logic [1:0] erase_kind, seen_kind;
  logic [23:0] erase_base, seen_base, a;
  logic [31:0] rx;
  logic [1:0] st;
  logic [7:0] ops [4] = '{8'h52, 8'hd8, 8'h60, 8'hc7};
  int fail_count = 0;
  int checks_done = 0;
  int pulses = 0;
  assign st = {deep_sleep, op_in_progress_flag};
  // a released data line floats up, so an undriven reply reads as ones, not a held bit
  assign so_line = serial_out_en ? serial_out : 1'b1;
  always #20 core_clk = ~core_clk;
  // the launch pulse lasts one cycle, so it is caught on the edge
  always @(posedge core_clk) begin
    if (erase_pulse === 1'b1) begin
      pulses++;
      seen_kind = erase_kind;
      seen_base = erase_base;
    end
  end
  flash_erase_power_id #(.erase_cycles_block(50), .erase_cycles_full(600), .sleep_cycles(10),
    .wake_plain_cycles(10), .wake_with_id_cycles(12), .maker_id(mk), .part_id(pt))
    i_flash_erase_power_id (.core_clk, .rst_n, .chip_sel_n, .serial_clk, .serial_in,
    .serial_out, .serial_out_en, .protect_range, .protect_complement, .write_latch_flag,
    .op_in_progress_flag, .deep_sleep, .standby, .erase_pulse, .erase_kind, .erase_base);
  flash_host_model host (.core_clk, .chip_sel_n, .serial_clk, .serial_in, .serial_out(so_line));
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // bounded wait on busy (0) or sleep (1); running out counts as a mismatch
  task automatic wait_for(input int sel, input logic v);
    int n;
    n = 0;
    while (st[sel] !== v && n < 1000) begin
      @(negedge core_clk);
      n++;
    end
    if (n >= 1000) begin
      check("wait", 0, 1);
      results();
    end
  endtask
  function automatic logic [25:0] exp_of(input logic [7:0] op, input logic [23:0] ad);
    case (op)
      8'h52: return {2'h1, ad & 24'hff8000};
      8'hd8: return {2'h2, ad & 24'hff0000};
      default: return {2'h3, 24'h000000};
    endcase
  endfunction
  task automatic send(input logic [31:0] tx, input int n);
    host.frame(tx, n, 0, rx);
  endtask
  // write enable, then the first n bits of opcode and address; launch expected or not
  task automatic erase(input logic [7:0] op, input logic [23:0] ad, input int n, input bit go);
    int p;
    p = pulses;
    send(32'h06, 8);
    check("latch set", write_latch_flag, 1'b1);
    send({op, ad} >> (32 - n), n);
    check("launch", pulses - p, go);
    if (go) begin
      check("kind base", {seen_kind, seen_base}, exp_of(op, ad));
      check("busy", op_in_progress_flag, 1'b1);
      wait_for(0, 1'b0);
      check("latch clear", write_latch_flag, 1'b0);
    end
  endtask
  initial begin
    void'($urandom(32'hb16d1709));
    repeat (5) @(negedge core_clk);
    rst_n = 1'b1;
    repeat (4) @(negedge core_clk);
    check("power up", {deep_sleep, standby, write_latch_flag}, 3'b010);
    a = 24'($urandom);
    send({8'h52, a}, 32);
    check("no latch", pulses, 0);
    // every erase code, random address and unused protect bits
    for (int i = 0; i < 4; i++) begin
      a = 24'($urandom);
      protect_range = 5'($urandom) & 5'h18;
      erase(ops[i], a, i < 2 ? 32 : 8, 1'b1);
    end
    protect_range = 5'h07;
    protect_complement = 1'b1;
    erase(8'hc7, a, 8, 1'b1);
    protect_range = 5'h02;
    protect_complement = 1'b0;
    erase(8'h60, a, 8, 1'b0);
    erase(8'hd8, 24'($urandom), 32, 1'b0);
    protect_range = 5'h00;
    erase(8'h52, a, 31, 1'b0);
    erase(8'h60, a, 9, 1'b0);
    // sleep and wake requests during a long erase leave it running
    send(32'h06, 8);
    send(32'h60, 8);
    send(32'hb9, 8);
    host.frame({8'hab, 24'($urandom)}, 32, 8, rx);
    check("busy kept", st, 2'b01);
    check("no id busy", rx[7:0], 8'hff);
    wait_for(0, 1'b0);
    // sleep, locked against erase, then each way out
    for (int w = 0; w < 3; w++) begin
      send(32'hb9, 8);
      wait_for(1, 1'b1);
      send(32'h06, 8);
      send(32'hc7, 8);
      check("asleep", {op_in_progress_flag, write_latch_flag}, 2'b00);
      if (w == 0) send(32'hab, 8);
      if (w == 1) host.frame({8'hab, 24'($urandom)}, 32, 16, rx);
      if (w == 1) check("part id", rx[15:0], {pt, pt});
      if (w == 2) send(32'h66, 8);
      if (w == 2) send(32'h99, 8);
      wait_for(1, 1'b0); // select held high through the wake delay
    end
    host.frame({8'h90, 24'h000000}, 32, 32, rx);
    check("ids from 0", rx, {mk, pt, mk, pt});
    host.frame({8'h90, 24'h000001}, 32, 32, rx);
    check("ids from 1", rx, {pt, mk, pt, mk});
    results();
  end
endmodule

// ### flash_host_model.sv
`timescale 1ns/100ps
// behavioural host link controller: select, link clock, data and reply capture
module flash_host_model (
  // clock
  input wire logic core_clk,
  // link pins
  output logic chip_sel_n,
  output logic serial_clk,
  output logic serial_in,
  input wire logic serial_out
);
  initial begin
    chip_sel_n = 1'b1;
    serial_clk = 1'b0;
    serial_in = 1'b0;
  end
  // one link period is 8 core cycles; the link clock rests low between frames
  task automatic frame(input logic [31:0] tx, input int ntx, input int nrx,
                       output logic [31:0] rx);
    rx = '0;
    @(negedge core_clk);
    chip_sel_n = 1'b0;
    for (int i = 0; i < ntx + nrx; i++) begin
      if (i < ntx) serial_in = tx[ntx-1-i];
      else serial_in = ~serial_in; // released line must not hold its last value
      repeat (4) @(negedge core_clk);
      serial_clk = 1'b1;
      @(negedge core_clk);
      if (i >= ntx) rx = {rx[30:0], serial_out}; // reply bit is steady well past the rise
      repeat (3) @(negedge core_clk);
      serial_clk = 1'b0;
    end
    repeat (4) @(negedge core_clk);
    chip_sel_n = 1'b1; // select rises four core cycles after the last link clock fall
    serial_in = ~serial_in;
    repeat (6) @(negedge core_clk);
  endtask
endmodule

// ### sync_edge.sv
`timescale 1ns/100ps
// two-flop synchroniser with edge pulses taken behind the second stage
module sync_edge (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // asynchronous level in, synchronised level and edges out
  input wire logic async_in,
  input wire logic reset_level,
  output logic level,
  output logic rise,
  output logic fall
);
  logic stage1;
  logic stage2;
  logic stage3;
  // stage1 feeds only stage2; edges come from stage2 versus stage3
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      stage1 <= 1'b1;
      stage2 <= 1'b1;
      stage3 <= 1'b1;
    end else begin
      stage1 <= async_in;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end
  // reset_level kept for port symmetry; all stages reset high (idle link)
  assign level = stage2 | (reset_level & 1'b0);
  assign rise = stage2 & ~stage3;
  assign fall = ~stage2 & stage3;
endmodule
